// *** inc/arwc_pkg.sv ***
// Package: register map, field layout and reset values of the compare monitor
package arwc_pkg;

    // ------------------------------------------------------------------
    // Register offsets (byte addresses, word index = offset / 4)
    // ------------------------------------------------------------------
    localparam logic [3:0] CMP_REG_OFFSET    = 4'h0;
    localparam logic [3:0] STATUS_REG_OFFSET = 4'h4;
    localparam logic [3:0] MASK_REG_OFFSET   = 4'h8;
    localparam logic [3:0] RESULT_REG_OFFSET = 4'hc;
    localparam int         ADDR_W            = 4;

    // ------------------------------------------------------------------
    // Compare register fields
    // ------------------------------------------------------------------
    localparam int EN_BIT      = 0;
    localparam int IE_BIT      = 1;
    localparam int COND_BIT    = 2;
    localparam int CHAN_LSB    = 3;
    localparam int CHAN_W      = 5;
    localparam int MCNT_LSB    = 8;
    localparam int MCNT_W      = 4;
    localparam int THR_LSB     = 16;
    localparam int THR_W       = 12;
    localparam int RESULT_W    = 12;

    // ------------------------------------------------------------------
    // Status / mask fields
    // ------------------------------------------------------------------
    localparam int FLAG_BIT    = 0;
    localparam int EVT_W       = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] CMP_RESET    = 32'h0000_0000;
    localparam logic [0:0]  MASK_RESET   = 1'h0;
    localparam logic [4:0]  MCNT_RESET   = 5'h00;

    // Bus answer state
    typedef enum logic [0:0] {
        ARWC_IDLE = 1'b0,
        ARWC_RESP = 1'b1
    } arwc_bus_state_type;

endpackage : arwc_pkg

// *** inc/arwc_cmp_if.sv ***
// Interface: compare settings and match result between top and comparator
`timescale 1ns/1ns
interface arwc_cmp_if;
    logic [11:0] result;
    logic [11:0] threshold;
    logic        condition;
    logic        match;
    modport top (output result, output threshold, output condition, input match);
    modport cmp (input result, input threshold, input condition, output match);
endinterface : arwc_cmp_if

// *** rtl/arwc_comparator.sv ***
// Comparator: less-than or greater-or-equal test of a result against threshold
`timescale 1ns/1ns
module arwc_comparator (
    arwc_cmp_if.cmp cmp_if
);
    // Condition 0: below threshold, 1: at or above threshold
    assign cmp_if.match = cmp_if.condition ? (cmp_if.result >= cmp_if.threshold)
                                           : (cmp_if.result <  cmp_if.threshold);
endmodule : arwc_comparator

// *** rtl/arwc_top.sv ***
// Top: conversion result compare monitor with Avalon-MM registers and interrupt
`timescale 1ns/1ns
module arwc_top (
    input  wire logic        clk_i,
    input  wire logic        nrst_i,
    input  wire logic [3:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        result_valid_i,
    input  wire logic [4:0]  result_channel_i,
    input  wire logic [11:0] result_data_i,
    output logic             irq_o
);

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [31:0]                  compare_register_q;
    logic                         compare_match_flag_q;
    logic                         mask_q;
    logic [arwc_pkg::MCNT_W:0]    match_cnt_q;
    logic [11:0]                  last_result_q;
    logic [31:0]                  readdata_q;
    arwc_pkg::arwc_bus_state_type bus_state_q;

    logic                         compare_enable;
    logic                         compare_irq_enable;
    logic [arwc_pkg::CHAN_W-1:0]  channel_sel;
    logic [arwc_pkg::MCNT_W-1:0]  match_count_limit;
    logic                         sample_hit;
    logic                         count_step;
    logic                         flag_set;
    logic                         bus_write;
    logic                         bus_read;
    logic [31:0]                  wmask;

    assign compare_enable     = compare_register_q[arwc_pkg::EN_BIT];
    assign compare_irq_enable = compare_register_q[arwc_pkg::IE_BIT];
    assign channel_sel        = compare_register_q[arwc_pkg::CHAN_LSB +: arwc_pkg::CHAN_W];
    assign match_count_limit  = compare_register_q[arwc_pkg::MCNT_LSB +: arwc_pkg::MCNT_W];

    // ------------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------------
    arwc_cmp_if cmp_bus ();

    assign cmp_bus.result    = result_data_i;
    assign cmp_bus.threshold = compare_register_q[arwc_pkg::THR_LSB +: arwc_pkg::THR_W];
    assign cmp_bus.condition = compare_register_q[arwc_pkg::COND_BIT];

    arwc_comparator u_cmp (
        .cmp_if (cmp_bus.cmp)
    );

    // ------------------------------------------------------------------
    // Match counting
    // ------------------------------------------------------------------
    assign sample_hit = compare_enable && result_valid_i
                        && (result_channel_i == channel_sel);
    assign count_step = sample_hit && cmp_bus.match;
    assign flag_set   = count_step
                        && (match_cnt_q + 5'h01 == {1'b0, match_count_limit} + 5'h01);

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            match_cnt_q <= arwc_pkg::MCNT_RESET;
        end else if (!compare_enable || flag_set) begin
            match_cnt_q <= arwc_pkg::MCNT_RESET;
        end else if (count_step) begin
            match_cnt_q <= match_cnt_q + 5'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            last_result_q <= 12'h000;
        end else if (sample_hit) begin
            last_result_q <= result_data_i;
        end
    end

    // ------------------------------------------------------------------
    // Avalon-MM slave: one wait cycle, answer on second edge
    // ------------------------------------------------------------------
    assign bus_write = (bus_state_q == arwc_pkg::ARWC_RESP) && avs_write_i;
    assign bus_read  = (bus_state_q == arwc_pkg::ARWC_IDLE) && avs_read_i;
    assign avs_waitrequest_o = (avs_read_i || avs_write_i)
                               && (bus_state_q == arwc_pkg::ARWC_IDLE);
    assign avs_readdata_o = readdata_q;

    always_comb begin
        wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                 {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            bus_state_q <= arwc_pkg::ARWC_IDLE;
        end else if (bus_state_q == arwc_pkg::ARWC_IDLE) begin
            if (avs_read_i || avs_write_i) begin
                bus_state_q <= arwc_pkg::ARWC_RESP;
            end
        end else begin
            bus_state_q <= arwc_pkg::ARWC_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            compare_register_q <= arwc_pkg::CMP_RESET;
        end else if (bus_write && avs_address_i == arwc_pkg::CMP_REG_OFFSET) begin
            compare_register_q <= (compare_register_q & ~wmask)
                                  | (avs_writedata_i & wmask & 32'h0fff_0fff);
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            mask_q <= arwc_pkg::MASK_RESET;
        end else if (bus_write && avs_address_i == arwc_pkg::MASK_REG_OFFSET
                     && avs_byteenable_i[0]) begin
            mask_q <= avs_writedata_i[arwc_pkg::FLAG_BIT];
        end
    end

    // Set wins over write-one-to-clear
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            compare_match_flag_q <= 1'b0;
        end else if (flag_set) begin
            compare_match_flag_q <= 1'b1;
        end else if (bus_write && avs_address_i == arwc_pkg::STATUS_REG_OFFSET
                     && avs_byteenable_i[0] && avs_writedata_i[arwc_pkg::FLAG_BIT]) begin
            compare_match_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            readdata_q <= 32'h0000_0000;
        end else if (bus_read) begin
            if (avs_address_i == arwc_pkg::CMP_REG_OFFSET) begin
                readdata_q <= compare_register_q;
            end else if (avs_address_i == arwc_pkg::STATUS_REG_OFFSET) begin
                readdata_q <= {31'h0, compare_match_flag_q};
            end else if (avs_address_i == arwc_pkg::MASK_REG_OFFSET) begin
                readdata_q <= {31'h0, mask_q};
            end else if (avs_address_i == arwc_pkg::RESULT_REG_OFFSET) begin
                readdata_q <= {11'h0, match_cnt_q, 4'h0, last_result_q};
            end else begin
                readdata_q <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------
    assign irq_o = compare_match_flag_q && compare_irq_enable && mask_q;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    flag_needs_enable_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        $rose(compare_match_flag_q) |-> $past(compare_enable) && $past(result_valid_i))
        else $error("flag set without enabled sample");

    below_counts_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        sample_hit && !compare_register_q[arwc_pkg::COND_BIT]
        && result_data_i < cmp_bus.threshold && !flag_set
        |=> match_cnt_q == $past(match_cnt_q) + 5'h01)
        else $error("below-threshold result not counted");

    above_counts_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        sample_hit && compare_register_q[arwc_pkg::COND_BIT]
        && result_data_i >= cmp_bus.threshold && !flag_set
        |=> match_cnt_q == $past(match_cnt_q) + 5'h01)
        else $error("at-or-above result not counted");

    flag_at_limit_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        count_step && match_cnt_q == {1'b0, match_count_limit} |=> compare_match_flag_q)
        else $error("flag not set at limit plus one");

    irq_follow_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        flag_set && compare_irq_enable && mask_q && !bus_write |=> irq_o)
        else $error("interrupt missing after flag");

    cnt_clear_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        !compare_enable |=> match_cnt_q == 5'h00)
        else $error("counter not cleared when disabled");

    cnt_flag_clear_a: assert property (
        @(posedge clk_i) disable iff (!nrst_i)
        flag_set |=> match_cnt_q == 5'h00)
        else $error("counter not cleared when flag set");

endmodule : arwc_top

// *** tb/arwc_result_src.sv ***
// Partner: conversion result source feeding the compare monitor
`timescale 1ns/1ns
module arwc_result_src (
    input  wire logic   clk_i,
    output logic        result_valid_o,
    output logic [4:0]  result_channel_o,
    output logic [11:0] result_data_o
);
    initial begin
        result_valid_o   = 1'b0;
        result_channel_o = 5'h00;
        result_data_o    = 12'h000;
    end
    // One-cycle load pulse, then the lines turn to junk
    task automatic send(input logic [4:0] c, input logic [11:0] d);
        @(posedge clk_i);
        result_valid_o   <= 1'b1;
        result_channel_o <= c;
        result_data_o    <= d;
        @(posedge clk_i);
        result_valid_o   <= 1'b0;
        result_channel_o <= ~c;
        result_data_o    <= ~d;
    endtask : send
endmodule : arwc_result_src

// *** tb/tb.sv ***
// Testbench: randomised compare monitor checks over Avalon-MM
`timescale 1ns/1ns
module tb;
    logic        clk_i  = 1'b0;
    logic        nrst_i = 1'b0;
    logic [3:0]  adr    = 4'h0;
    logic        rd     = 1'b0;
    logic        wr     = 1'b0;
    logic [31:0] wdat   = 32'h0;
    logic [31:0] rdat;
    logic        wreq;
    logic        vld;
    logic [4:0]  ch;
    logic [11:0] dat;
    logic        irq;
    int          n_fail     = 0;
    int          num_checks = 0;
    int          cyc        = 0;
    int          cnt;
    logic [31:0] v;
    logic [11:0] thr;
    logic [11:0] d;
    logic [4:0]  sel;
    logic [4:0]  c5;
    logic [3:0]  lim;
    logic        cond;
    logic        ie;
    logic        msk;
    logic        flg;
    logic [11:0] lr         = 12'h000;

    always #2 clk_i = ~clk_i;

    arwc_top dut (.clk_i(clk_i), .nrst_i(nrst_i), .avs_address_i(adr), .avs_read_i(rd),
        .avs_write_i(wr), .avs_writedata_i(wdat), .avs_byteenable_i(4'hf),
        .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .result_valid_i(vld),
        .result_channel_i(ch), .result_data_i(dat), .irq_o(irq));
    arwc_result_src src (.clk_i(clk_i), .result_valid_o(vld), .result_channel_o(ch),
        .result_data_o(dat));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] s, input logic [31:0] e);
        num_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : check

    // Hold request until waitrequest low, data taken at that edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] x);
        @(posedge clk_i);
        adr  <= a;
        wdat <= x;
        rd   <= ~w;
        wr   <= w;
        do @(posedge clk_i); while (wreq !== 1'b0);
        v = rdat;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus

    function automatic logic hit(input logic [11:0] x);
        return cond ? (x >= thr) : (x < thr);
    endfunction : hit

    function automatic logic [31:0] cmpw(input logic en);
        return {4'h0, thr, 4'h0, lim, sel, cond, ie, en};
    endfunction : cmpw

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            n_fail++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'h1bb1));
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        for (int a = 0; a < 4; a++) begin
            bus(1'b0, 4'(a * 4), 32'h0);
            check(v, 32'h0);
        end
        check({31'h0, irq}, 32'h0);
        $display("test reset done");
        for (int r = 0; r < 8; r++) begin
            cond = r[0];
            ie   = 1'($urandom);
            msk  = 1'($urandom);
            sel  = 5'($urandom);
            lim  = 4'($urandom % 4);
            thr  = (r < 2) ? 12'(r * 12'hfff) : 12'($urandom);
            cnt  = 0;
            flg  = 1'b0;
            bus(1'b1, 4'h8, {31'h0, msk});
            bus(1'b1, 4'h0, cmpw(1'b1));
            bus(1'b0, 4'h0, 32'h0);
            check(v, cmpw(1'b1));
            for (int k = 0; k < 10; k++) begin
                case ($urandom % 4)
                    0: d = thr;
                    1: d = thr - 12'h1;
                    default: d = 12'($urandom);
                endcase
                c5 = ($urandom % 3 == 0) ? ~sel : sel;
                src.send(c5, d);
                if (c5 == sel) lr = d;
                if (c5 == sel && hit(d)) cnt++;
                if (cnt == lim + 1) begin
                    cnt = 0;
                    flg = 1'b1;
                end
                bus(1'b0, 4'h4, 32'h0);
                check({31'h0, v[0]}, {31'h0, flg});
                bus(1'b0, 4'hc, 32'h0);
                check({27'h0, v[20:16]}, 32'(cnt));
                check({20'h0, v[11:0]}, {20'h0, lr});
                @(negedge clk_i);
                check({31'h0, irq}, {31'h0, flg & ie & msk});
            end
            bus(1'b1, 4'h4, 32'h1);
            bus(1'b1, 4'h0, cmpw(1'b0));
            src.send(sel, thr);
            src.send(sel, thr - 12'h1);
            bus(1'b0, 4'h4, 32'h0);
            check(v, 32'h0);
            bus(1'b0, 4'hc, 32'h0);
            check({27'h0, v[20:16]}, 32'h0);
            check({20'h0, v[11:0]}, {20'h0, lr});
            $display("test round %0d done", r);
        end
        print_verdict();
    end
endmodule : tb
